// ==== include/cbti_defs.svh ====
// constants for the bit, flag and data transfer execution core
`ifndef CBTI_DEFS_SVH
`define CBTI_DEFS_SVH

// ============================================================
// status flag bit positions
`define CBTI_FLAG_C 3'h0
`define CBTI_FLAG_Z 3'h1
`define CBTI_FLAG_N 3'h2
`define CBTI_FLAG_V 3'h3
`define CBTI_FLAG_S 3'h4
`define CBTI_FLAG_H 3'h5
`define CBTI_FLAG_T 3'h6
`define CBTI_FLAG_I 3'h7

// ============================================================
// pointer pair base registers (low byte index)
`define CBTI_PAIR_ONE   5'h1A
`define CBTI_PAIR_TWO   5'h1C
`define CBTI_PAIR_THREE 5'h1E

// ============================================================
// reset values
`define CBTI_FLAGS_RST 8'h00
`define CBTI_SP_RST    16'h00FF

// ============================================================
// cycle counts
`define CBTI_CYC_MEM  2
`define CBTI_CYC_PROG 3

// ============================================================
// bus register byte offsets
`define CBTI_OFF_STATUS 8'h00
`define CBTI_OFF_STACK  8'h04
`define CBTI_OFF_STATE  8'h08

`endif

// ==== include/cbti_pkg.sv ====
// types shared by the execution core and its flag unit
package cbti_pkg;

  // ============================================================
  // operations
  typedef enum logic [3:0] {
    OP_NOP         = 4'h0,
    OP_SHIFT_RA    = 4'h1,
    OP_SWAP        = 4'h2,
    OP_FLAG_SET    = 4'h3,
    OP_FLAG_CLR    = 4'h4,
    OP_BIT_TO_FLAG = 4'h5,
    OP_FLAG_TO_BIT = 4'h6,
    OP_WORD_COPY   = 4'h7,
    OP_MEM_RD      = 4'h8,
    OP_MEM_WR      = 4'h9,
    OP_PROG_RD     = 4'hA,
    OP_STACK_PUT   = 4'hB,
    OP_STACK_TAKE  = 4'hC
  } cbti_op_e;

  // ============================================================
  // addressing modes and pointer pairs
  typedef enum logic [2:0] {
    AM_PLAIN    = 3'h0,
    AM_POST_INC = 3'h1,
    AM_PRE_DEC  = 3'h2,
    AM_DISP     = 3'h3,
    AM_ABS      = 3'h4
  } cbti_amode_e;

  typedef enum logic [1:0] {
    PTR_ONE   = 2'h0,
    PTR_TWO   = 2'h1,
    PTR_THREE = 2'h2
  } cbti_ptr_e;

endpackage

// ==== rtl/cbti_alu.sv ====
// single-cycle result and flag unit for shift, swap and flag operations
`timescale 1ns/100ps
`include "cbti_defs.svh"

module cbti_alu
  import cbti_pkg::*;
(
  input  wire cbti_op_e   op,
  input  wire logic [7:0] opnd,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] flags_in,
  output logic      [7:0] result,
  output logic      [7:0] flags_out,
  output logic            wr_en
);

  // ============================================================
  // data paths
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire [7:0] shr_res  = {opnd[7], opnd[7:1]};
  wire [7:0] swp_res  = {opnd[3:0], opnd[7:4]};
  wire       spare    = flags_in[`CBTI_FLAG_T];
  wire [7:0] ins_res  = (opnd & ~bit_mask) | (spare ? bit_mask : 8'h00);
  wire       shr_n    = opnd[7];
  wire       shr_c    = opnd[0];

  // result selection; the shift, swap and bit insert write back
  assign result = (op == OP_SHIFT_RA)    ? shr_res :
                  (op == OP_SWAP)        ? swp_res :
                  (op == OP_FLAG_TO_BIT) ? ins_res : opnd;
  assign wr_en  = (op == OP_SHIFT_RA) || (op == OP_SWAP) || (op == OP_FLAG_TO_BIT);

  // flag update; every op not listed leaves the status byte as it is
  always_comb begin
    flags_out = flags_in;
    unique case (op)
      OP_SHIFT_RA: begin
        flags_out[`CBTI_FLAG_C] = shr_c;
        flags_out[`CBTI_FLAG_N] = shr_n;
        flags_out[`CBTI_FLAG_Z] = (shr_res == 8'h00);
        flags_out[`CBTI_FLAG_V] = shr_n ^ shr_c;
      end
      OP_FLAG_SET:    flags_out = flags_in | bit_mask;
      OP_FLAG_CLR:    flags_out = flags_in & ~bit_mask;
      OP_BIT_TO_FLAG: flags_out[`CBTI_FLAG_T] = opnd[bit_sel];
      default:        flags_out = flags_in;
    endcase
  end

endmodule

// ==== rtl/cbti_core.sv ====
// execution core: working registers, status flags, pointers, stack, memory ports
`timescale 1ns/100ps
`include "cbti_defs.svh"

module cbti_core
  import cbti_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // operation issue
  input  wire logic        op_valid,
  input  wire cbti_op_e    op_code,
  input  wire logic [4:0]  op_rd,
  input  wire logic [4:0]  op_rr,
  input  wire logic [2:0]  op_bit,
  input  wire cbti_amode_e op_mode,
  input  wire cbti_ptr_e   op_ptr,
  input  wire logic [5:0]  op_disp,
  input  wire logic [15:0] op_addr,
  output logic             op_ready,
  output logic             op_done,
  // data memory
  output logic [15:0]      dm_addr,
  output logic [7:0]       dm_wdata,
  output logic             dm_we,
  output logic             dm_re,
  input  wire logic [7:0]  dm_rdata,
  // program memory
  output logic [15:0]      pm_addr,
  output logic             pm_re,
  input  wire logic [7:0]  pm_rdata,
  // status view
  output logic [7:0]       flags,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  // ============================================================
  // state
  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_PROG1, ST_PROG2} cbti_state_e;

  cbti_state_e st_q;
  logic [7:0]  rf_q [32];
  logic [7:0]  flags_q;
  logic [15:0] sp_q;
  logic [4:0]  ld_idx_q;
  logic        ld_pend_q;
  logic        ready_q;
  logic        done_q;
  logic [15:0] dm_addr_q;
  logic [7:0]  dm_wdata_q;
  logic        dm_we_q;
  logic        dm_re_q;
  logic [15:0] pm_addr_q;
  logic        pm_re_q;
  logic        bus_wr_q;
  logic [7:0]  bus_off_q;
  logic        bus_hit_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;

  // ============================================================
  // helpers
  function automatic logic [4:0] base_of(input cbti_ptr_e p);
    base_of = (p == PTR_ONE) ? `CBTI_PAIR_ONE :
              (p == PTR_TWO) ? `CBTI_PAIR_TWO : `CBTI_PAIR_THREE;
  endfunction

  function automatic logic [15:0] pair_val(input logic [7:0] hi, input logic [7:0] lo);
    pair_val = {hi, lo};
  endfunction

  // ============================================================
  // operation decode
  wire       accept    = ce & op_valid & ready_q;
  wire       is_prog   = (op_code == OP_PROG_RD);
  wire       is_mrd    = (op_code == OP_MEM_RD);
  wire       is_mwr    = (op_code == OP_MEM_WR);
  wire       is_put    = (op_code == OP_STACK_PUT);
  wire       is_take   = (op_code == OP_STACK_TAKE);
  wire       is_word   = (op_code == OP_WORD_COPY);
  wire       is_dm     = is_mrd | is_mwr | is_put | is_take;
  wire       post_inc  = (op_mode == AM_POST_INC);
  wire       pre_dec   = (op_mode == AM_PRE_DEC);

  // pointer arithmetic; the program read always walks the third pair
  wire [4:0]  base     = is_prog ? `CBTI_PAIR_THREE : base_of(op_ptr);
  wire [15:0] ptr_v    = pair_val(rf_q[{base[4:1], 1'b1}], rf_q[{base[4:1], 1'b0}]);
  wire [15:0] ptr_inc  = ptr_v + 16'h0001;
  wire [15:0] ptr_dec  = ptr_v - 16'h0001;
  wire [15:0] ptr_disp = ptr_v + {10'h000, op_disp};
  wire [15:0] sp_inc   = sp_q + 16'h0001;
  wire [15:0] sp_dec   = sp_q - 16'h0001;

  // effective address: pre-decrement uses the new value, post-inc the old
  wire [15:0] eff_addr = pre_dec              ? ptr_dec :
                         (op_mode == AM_DISP) ? ptr_disp :
                         (op_mode == AM_ABS)  ? op_addr :
                         ptr_v;
  // stack grows down: put stores then moves, take moves then reads
  wire [15:0] dm_next  = is_put  ? sp_q :
                         is_take ? sp_inc : eff_addr;

  // ============================================================
  // single-cycle unit
  wire [7:0] alu_res;
  wire [7:0] alu_flags;
  wire       alu_wr;
  wire [7:0] alu_opnd = (op_code == OP_BIT_TO_FLAG) ? rf_q[op_rr] : rf_q[op_rd];

  cbti_alu u_alu (
    .op        (op_code),
    .opnd      (alu_opnd),
    .bit_sel   (op_bit),
    .flags_in  (flags_q),
    .result    (alu_res),
    .flags_out (alu_flags),
    .wr_en     (alu_wr)
  );

  // ============================================================
  // register file write ports
  // port b: pointer update at issue, or a whole pair copy
  wire        ptr_upd = accept & (is_mrd | is_mwr | is_prog) & (post_inc | pre_dec);
  wire        pb_en   = ptr_upd | (accept & is_word);
  wire [3:0]  pb_idx  = is_word ? op_rd[4:1] : base[4:1];
  wire [15:0] pb_data = is_word ? pair_val(rf_q[{op_rr[4:1], 1'b1}], rf_q[{op_rr[4:1], 1'b0}])
                                : (post_inc ? ptr_inc : ptr_dec);
  // port a: single-cycle result at issue, memory byte at completion
  wire        mem_fin = ce & (st_q == ST_MEM) & ld_pend_q;
  wire        prg_fin = ce & (st_q == ST_PROG2);
  wire        pa_en   = (accept & alu_wr) | mem_fin | prg_fin;
  wire [4:0]  pa_idx  = (st_q == ST_IDLE) ? op_rd : ld_idx_q;
  wire [7:0]  pa_data = (st_q == ST_IDLE) ? alu_res :
                        (st_q == ST_PROG2) ? pm_rdata : dm_rdata;

  // port a is applied last so a loaded byte beats a pointer update on the same pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) rf_q[i] <= 8'h00;
    end else begin
      if (pb_en) begin
        rf_q[{pb_idx, 1'b0}] <= pb_data[7:0];
        rf_q[{pb_idx, 1'b1}] <= pb_data[15:8];
      end
      if (pa_en) begin
        rf_q[pa_idx] <= pa_data;
      end
    end
  end

  // ============================================================
  // status flags: only the single-cycle unit changes them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `CBTI_FLAGS_RST;
    end else if (accept) begin
      flags_q <= alu_flags;
    end
  end

  // ============================================================
  // stack position; a stack op at the same edge beats a bus write
  wire bus_sp_wr = bus_wr_q & (bus_off_q == `CBTI_OFF_STACK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= `CBTI_SP_RST;
    end else if (ce) begin
      if (accept & is_put) begin
        sp_q <= sp_dec;
      end else if (accept & is_take) begin
        sp_q <= sp_inc;
      end else if (bus_sp_wr) begin
        sp_q <= hwdata[15:0];
      end
    end
  end

  // ============================================================
  // sequencer: memory ops hold one extra cycle, program reads two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      ready_q   <= 1'b1;
      done_q    <= 1'b0;
      ld_idx_q  <= 5'h00;
      ld_pend_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (accept && is_dm) begin
            st_q      <= ST_MEM;
            ready_q   <= 1'b0;
            ld_pend_q <= is_mrd | is_take;
            ld_idx_q  <= op_rd;
          end else if (accept && is_prog) begin
            st_q      <= ST_PROG1;
            ready_q   <= 1'b0;
            ld_idx_q  <= op_rd;
          end else if (accept) begin
            done_q    <= 1'b1;
          end
        end
        ST_MEM: begin
          st_q      <= ST_IDLE;
          ready_q   <= 1'b1;
          done_q    <= 1'b1;
          ld_pend_q <= 1'b0;
        end
        ST_PROG1: st_q <= ST_PROG2;
        ST_PROG2: begin
          st_q    <= ST_IDLE;
          ready_q <= 1'b1;
          done_q  <= 1'b1;
        end
      endcase
    end
  end

  // ============================================================
  // memory port registers; strobes last exactly one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dm_addr_q  <= 16'h0000;
      dm_wdata_q <= 8'h00;
      dm_we_q    <= 1'b0;
      dm_re_q    <= 1'b0;
      pm_addr_q  <= 16'h0000;
      pm_re_q    <= 1'b0;
    end else if (ce) begin
      dm_we_q <= accept & (is_mwr | is_put);
      dm_re_q <= accept & (is_mrd | is_take);
      pm_re_q <= accept & is_prog;
      if (accept && is_dm) begin
        dm_addr_q  <= dm_next;
        dm_wdata_q <= rf_q[op_rr];
      end
      if (accept && is_prog) begin
        pm_addr_q <= ptr_v;
      end
    end
  end

  // ============================================================
  // ahb-lite slave, zero wait states, always okay
  wire        bus_take = hsel & htrans[1] & hready;
  wire        bus_hit  = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
  wire [7:0]  bus_off  = haddr[7:0];
  // read mux; unmapped words read as zero
  wire [31:0] bus_rd   = !bus_hit                       ? 32'h0000_0000 :
                         (bus_off == `CBTI_OFF_STATUS)  ? {24'h000000, flags_q} :
                         (bus_off == `CBTI_OFF_STACK)   ? {16'h0000, sp_q} :
                         (bus_off == `CBTI_OFF_STATE)   ? {29'h0, ~ready_q, st_q} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_wr_q    <= 1'b0;
      bus_off_q   <= 8'h00;
      bus_hit_q   <= 1'b0;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else if (ce) begin
      hreadyout_q <= 1'b1;
      bus_wr_q    <= bus_take & hwrite & bus_hit;
      bus_hit_q   <= bus_take & bus_hit;
      if (bus_take) begin
        bus_off_q <= bus_off;
      end
      if (bus_take && !hwrite) begin
        hrdata_q <= bus_rd;
      end
    end
  end

  // ============================================================
  // outputs, all from flops except hresp, which is tied low
  assign op_ready  = ready_q;
  assign op_done   = done_q;
  assign dm_addr   = dm_addr_q;
  assign dm_wdata  = dm_wdata_q;
  assign dm_we     = dm_we_q;
  assign dm_re     = dm_re_q;
  assign pm_addr   = pm_addr_q;
  assign pm_re     = pm_re_q;
  assign flags     = flags_q;
  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;

endmodule

// ==== sim/cbti_core_monitor.sv ====
// checker for issue timing, flag updates and memory strobes of the core
`timescale 1ns/100ps
module cbti_core_monitor
  import cbti_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        op_valid,
  input wire cbti_op_e    op_code,
  input wire logic [2:0]  op_bit,
  input wire cbti_amode_e op_mode,
  input wire logic [15:0] op_addr,
  input wire logic        op_ready,
  input wire logic        op_done,
  input wire logic [15:0] dm_addr,
  input wire logic        dm_we,
  input wire logic        dm_re,
  input wire logic        pm_re,
  input wire logic [7:0]  flags
);
  // ============================================================
  // an operation is taken only when ready and enabled
  wire logic take;
  assign take = ce && op_valid && op_ready;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ============================================================
  // flag operations touch only their own bit
  a_flag_set_one: assert property (take && op_code == OP_FLAG_SET |=>
    flags == ($past(flags) | (8'h01 << $past(op_bit)))) else $error("flag set changed wrong bits");
  a_flag_clr_one: assert property (take && op_code == OP_FLAG_CLR |=>
    flags == ($past(flags) & ~(8'h01 << $past(op_bit)))) else $error("flag clear changed wrong bits");
  a_bit_flag_only: assert property (take && op_code == OP_BIT_TO_FLAG |=>
    ((flags ^ $past(flags)) & 8'hBF) == 8'h00 && op_done) else $error("bit copy touched other flags");
  a_flag_bit_keep: assert property (take && op_code == OP_FLAG_TO_BIT |=>
    $stable(flags) && op_done) else $error("flag copy altered flags");
  a_single_cycle_ops: assert property (take && op_code inside {OP_SHIFT_RA, OP_SWAP, OP_WORD_COPY} |=>
    op_done && op_ready) else $error("single cycle op late");
  // ============================================================
  // memory operations: two cycles (program reads three), strobes one cycle, flags kept
  a_mem_two_cycle: assert property (take && op_code inside {OP_MEM_RD, OP_MEM_WR, OP_STACK_PUT, OP_STACK_TAKE}
    |=> !op_ready ##1 (op_done && op_ready)) else $error("memory op not two cycles");
  a_abs_read_addr: assert property (take && op_code == OP_MEM_RD && op_mode == AM_ABS |=>
    dm_re && dm_addr == $past(op_addr)) else $error("absolute read address wrong");
  a_mem_flags_hold: assert property ((dm_re || dm_we) |=> $stable(flags) && !dm_re && !dm_we)
    else $error("flags moved during memory access");
  a_prog_three: assert property (take && op_code == OP_PROG_RD |=> pm_re ##1 !op_ready ##1 op_done)
    else $error("program read not three cycles");

  c_flag_set: cover property (take && op_code == OP_FLAG_SET);
  c_stack_put: cover property (take && op_code == OP_STACK_PUT);
  c_prog_read: cover property (pm_re ##2 op_done);
endmodule

bind cbti_core cbti_core_monitor u_mon (
  .clk      (clk),
  .rst_n    (rst_n),
  .ce       (ce),
  .op_valid (op_valid),
  .op_code  (op_code),
  .op_bit   (op_bit),
  .op_mode  (op_mode),
  .op_addr  (op_addr),
  .op_ready (op_ready),
  .op_done  (op_done),
  .dm_addr  (dm_addr),
  .dm_we    (dm_we),
  .dm_re    (dm_re),
  .pm_re    (pm_re),
  .flags    (flags)
);

// ==== sim/cbti_core_tb_top.sv ====
// self-checking bench: operations and bus accesses with expected results
`timescale 1ns/100ps
module cbti_core_tb_top
  import cbti_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  cbti_op_e    op_code = OP_NOP;
  cbti_amode_e op_mode = AM_PLAIN;
  cbti_ptr_e   op_ptr = PTR_ONE;
  logic [4:0]  op_rd = 5'h00, op_rr = 5'h00;
  logic [2:0]  op_bit = 3'h0;
  logic [5:0]  op_disp = 6'h00;
  logic [15:0] op_addr = 16'h0000, dm_addr, pm_addr;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  dm_wdata, dm_rdata, pm_rdata, flags, e;
  logic        op_ready, op_done, dm_we, dm_re, pm_re, hreadyout, hresp;
  int          n_errors = 0, checked = 0;

  always #2.5 clk = ~clk;

  // ============================================================
  // single slave: its ready is the bus ready; clock enable held on
  cbti_core u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .op_valid(op_valid), .op_code(op_code),
    .op_rd(op_rd), .op_rr(op_rr), .op_bit(op_bit), .op_mode(op_mode), .op_ptr(op_ptr), .op_disp(op_disp),
    .op_addr(op_addr), .op_ready(op_ready), .op_done(op_done), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata), .pm_addr(pm_addr), .pm_re(pm_re),
    .pm_rdata(pm_rdata), .flags(flags), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  cbti_mem_model u_mem (.clk(clk), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
    .dm_rdata(dm_rdata), .pm_addr(pm_addr), .pm_re(pm_re), .pm_rdata(pm_rdata));

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask

  // ============================================================
  // issue one op, then count edges from take to done
  task automatic op(input cbti_op_e c, input logic [4:0] d, input logic [4:0] r, input logic [2:0] b,
                    input cbti_amode_e m, input cbti_ptr_e p, input logic [5:0] q, input int cyc);
    int n;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_rd <= d;
    op_rr <= r;
    op_bit <= b;
    op_mode <= m;
    op_ptr <= p;
    op_disp <= q;
    @(posedge clk);
    op_valid <= 1'b0;
    n = 0;
    #1;
    while (op_done !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("op cycles", 32'(cyc - 1), 32'(n));
  endtask

  task automatic ld(input logic [4:0] d, input cbti_amode_e m, input cbti_ptr_e p, input logic [5:0] q,
                    input logic [15:0] a);
    @(posedge clk);
    op_addr <= a;
    op(OP_MEM_RD, d, 5'h00, 3'h0, m, p, q, 2);
  endtask

  task automatic st(input logic [4:0] r, input cbti_amode_e m, input cbti_ptr_e p, input logic [5:0] q,
                    input logic [15:0] a, input logic [7:0] ea, input logic [7:0] ev);
    @(posedge clk);
    op_addr <= a;
    op(OP_MEM_WR, 5'h00, r, 3'h0, m, p, q, 2);
    chk("data memory", {24'h0, ev}, {24'h0, u_mem.mem[ea]});
  endtask

  // ============================================================
  // single ahb-lite transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0, v);
    chk("bus read", ex, v);
  endtask

  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a hang stops the run as a failure
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end

  // ============================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    u_mem.mem[8'h10] = 8'hA5;
    u_mem.mem[8'h11] = 8'h40;
    u_mem.mem[8'h13] = 8'h50;
    u_mem.mem[8'h40] = 8'h3C;
    u_mem.mem[8'h3F] = 8'h6E;
    u_mem.mem[8'h55] = 8'h77;
    u_mem.prog[8'h50] = 8'hC3;
    chk("flags", 32'h0, {24'h0, flags});
    rdchk(32'h4, 32'hFF);
    rdchk(32'h20, 32'h0);
    e = 8'h00;
    for (int i = 0; i < 16; i++) begin
      op(i < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 5'h00, 5'h00, 3'(i), AM_PLAIN, PTR_ONE, 6'h00, 1);
      e = i < 8 ? (e | (8'h01 << i)) : (e & ~(8'h01 << (i - 8)));
      chk("flags", {24'h0, e}, {24'h0, flags});
    end
    ld(5'h01, AM_ABS, PTR_ONE, 6'h00, 16'h0010);
    ld(5'h1A, AM_ABS, PTR_ONE, 6'h00, 16'h0011);
    ld(5'h1E, AM_ABS, PTR_ONE, 6'h00, 16'h0013);
    st(5'h01, AM_ABS, PTR_ONE, 6'h00, 16'h0020, 8'h20, 8'hA5);
    op(OP_BIT_TO_FLAG, 5'h00, 5'h01, 3'h2, AM_PLAIN, PTR_ONE, 6'h00, 1);
    chk("flags", 32'h40, {24'h0, flags});
    op(OP_FLAG_TO_BIT, 5'h02, 5'h00, 3'h6, AM_PLAIN, PTR_ONE, 6'h00, 1);
    st(5'h02, AM_ABS, PTR_ONE, 6'h00, 16'h0021, 8'h21, 8'h40);
    ld(5'h03, AM_POST_INC, PTR_ONE, 6'h00, 16'h0000);
    st(5'h03, AM_PLAIN, PTR_ONE, 6'h00, 16'h0000, 8'h41, 8'h3C);
    st(5'h01, AM_PRE_DEC, PTR_ONE, 6'h00, 16'h0000, 8'h40, 8'hA5);
    ld(5'h04, AM_PRE_DEC, PTR_ONE, 6'h00, 16'h0000);
    st(5'h04, AM_ABS, PTR_ONE, 6'h00, 16'h0022, 8'h22, 8'h6E);
    ld(5'h05, AM_DISP, PTR_THREE, 6'h05, 16'h0000);
    st(5'h05, AM_DISP, PTR_THREE, 6'h06, 16'h0000, 8'h56, 8'h77);
    op(OP_PROG_RD, 5'h06, 5'h00, 3'h0, AM_POST_INC, PTR_THREE, 6'h00, 3);
    chk("program address", 32'h50, {16'h0, pm_addr});
    st(5'h06, AM_PLAIN, PTR_THREE, 6'h00, 16'h0000, 8'h51, 8'hC3);
    op(OP_STACK_PUT, 5'h00, 5'h01, 3'h0, AM_PLAIN, PTR_ONE, 6'h00, 2);
    chk("stack byte", 32'hA5, {24'h0, u_mem.mem[8'hFF]});
    rdchk(32'h4, 32'hFE);
    op(OP_STACK_TAKE, 5'h07, 5'h00, 3'h0, AM_PLAIN, PTR_ONE, 6'h00, 2);
    rdchk(32'h4, 32'hFF);
    op(OP_SHIFT_RA, 5'h07, 5'h00, 3'h0, AM_PLAIN, PTR_ONE, 6'h00, 1);
    chk("flags", 32'h45, {24'h0, flags});
    st(5'h07, AM_ABS, PTR_ONE, 6'h00, 16'h0023, 8'h23, 8'hD2);
    op(OP_SWAP, 5'h07, 5'h00, 3'h0, AM_PLAIN, PTR_ONE, 6'h00, 1);
    op(OP_WORD_COPY, 5'h08, 5'h06, 3'h0, AM_PLAIN, PTR_ONE, 6'h00, 1);
    st(5'h09, AM_ABS, PTR_ONE, 6'h00, 16'h0024, 8'h24, 8'h2D);
    st(5'h08, AM_ABS, PTR_ONE, 6'h00, 16'h0025, 8'h25, 8'hC3);
    // second pair, loaded from the third: displacement read, post-increment write
    op(OP_WORD_COPY, 5'h1C, 5'h1E, 3'h0, AM_PLAIN, PTR_ONE, 6'h00, 1);
    ld(5'h0A, AM_DISP, PTR_TWO, 6'h05, 16'h0000);
    st(5'h0A, AM_POST_INC, PTR_TWO, 6'h00, 16'h0000, 8'h51, 8'h77);
    st(5'h01, AM_PLAIN, PTR_TWO, 6'h00, 16'h0000, 8'h52, 8'hA5);
    // stack pointer is writable, status is read-only
    bus(1'b1, 32'h4, 32'h1234, v);
    rdchk(32'h4, 32'h1234);
    bus(1'b1, 32'h0, 32'hFF, v);
    rdchk(32'h0, 32'h45);
    tally_and_finish;
  end
endmodule

// ==== sim/cbti_mem_model.sv ====
// data sram and program flash standing behind the core's memory ports
`timescale 1ns/100ps
module cbti_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  input  wire logic        dm_re,
  output logic      [7:0]  dm_rdata,
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_re,
  output logic      [7:0]  pm_rdata
);
  logic [7:0] mem  [0:255] = '{default: 8'h00};
  logic [7:0] prog [0:255] = '{default: 8'h00};
  logic [7:0] pm_q = 8'h00;
  logic       pm_vld_q = 1'b0;
  // ============================================================
  // data is only good while its strobe window lasts; inverted otherwise so a late sample shows
  assign dm_rdata = dm_re ? mem[dm_addr[7:0]] : ~mem[dm_addr[7:0]];
  assign pm_rdata = pm_vld_q ? pm_q : ~pm_q;
  // flash answers one cycle after its strobe, sram writes on the strobe edge
  always @(posedge clk) begin
    if (dm_we) begin
      mem[dm_addr[7:0]] <= dm_wdata;
    end
    if (pm_re) begin
      pm_q <= prog[pm_addr[7:0]];
    end
    pm_vld_q <= pm_re;
  end
endmodule
